/* verilog/dbt_defs.svh */
`ifndef DBT_DEFS_SVH
`define DBT_DEFS_SVH

`define DBT_BUF_BANK 4'h0
`define DBT_BUF_TOP_ADDR 7'h0c
`define DBT_BUF_UMID_ADDR 7'h0d
`define DBT_BUF_LMID_ADDR 7'h0e
`define DBT_BUF_BOT_ADDR 7'h0f
`define DBT_CTL_WIDTH_ADDR 6'h07
`define DBT_WSEL_WIDE_BIT 0
`define DBT_PER_PTR_ADDR 7'h40
`define DBT_PTR_RST 16'h0000
`define DBT_BUF_RST 16'h0000
`define DBT_WSEL_RST 4'h0
`define DBT_MASK_ALL 4'hf
`define DBT_MASK_LOW 4'h3

`endif

/* verilog/dbt_pkg.sv */
package dbt_pkg;
   typedef enum logic [1:0] {
      DBT_IDLE = 2'b00,
      DBT_TBL_FETCH = 2'b01,
      DBT_GET_WAIT = 2'b10
   } dbt_state_t;

   typedef logic [3:0] dbt_nib_t;
   typedef logic [15:0] dbt_word_t;
endpackage

/* verilog/dbt_buf_mem.sv */
`include "dbt_defs.svh"

module dbt_buf_mem (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [1:0] nib_idx,
   input wire logic nib_we,
   input wire dbt_pkg::dbt_nib_t nib_wdata,
   input wire logic nib_rd,
   output dbt_pkg::dbt_nib_t nib_rdata,
   input wire logic wide_we,
   input wire logic [3:0] wide_mask,
   input wire dbt_pkg::dbt_word_t wide_wdata,
   output dbt_pkg::dbt_word_t word
);
   import dbt_pkg::*;

   dbt_word_t word_ff;
   dbt_nib_t rdata_ff;
   dbt_nib_t nxt_rdata;

   // Index 0 is the top nibble, so the word reads MSB first
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_nib
         dbt_nib_t nxt_nib;
         always_comb begin
            nxt_nib = word_ff[15-4*gi -: 4];
            // Engine transfers win; a core write in that cycle is dropped
            if (wide_we) begin
               if (wide_mask[3-gi]) begin
                  nxt_nib = wide_wdata[15-4*gi -: 4];
               end
            end else if (nib_we && nib_idx == 2'(gi)) begin
               nxt_nib = nib_wdata;
            end
         end
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               word_ff[15-4*gi -: 4] <= 4'(`DBT_BUF_RST >> (12-4*gi));
            end else begin
               word_ff[15-4*gi -: 4] <= nxt_nib;
            end
         end
      end
   endgenerate

   always_comb begin
      nxt_rdata = rdata_ff;
      if (nib_rd) begin
         nxt_rdata = word_ff[4'd15 - {nib_idx, 2'b00} -: 4];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdata_ff <= 4'h0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign nib_rdata = rdata_ff;
   assign word = word_ff;
endmodule // dbt_buf_mem

/* verilog/dbt_top.sv */
// Summary of operation
// - Buffer is 16 bits held in nibbles 0C to 0F of bank 0.
// - Top bit of 0C is the MSB; bottom bit of 0F is the LSB.
// - Ordinary data-memory reads and writes reach the buffer nibbles.
// - Table read fetches the program word at the table pointer into the buffer.
// - Table read width comes from the control register at address 07.
// - An 8-bit table read loads only the two low buffer nibbles.
// - A table read takes one return-stack level while it runs.
// - Table read may address every program-memory location.
// - One buffer serves both table reads and peripheral transfers.
// - Peripheral read copies the selected peripheral register into the buffer.
// - Peripheral write copies the buffer into the selected peripheral register.
// - Table pointer sits at peripheral address 40, read and written via buffer.
`include "dbt_defs.svh"

module dbt_top (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [3:0] dm_bank,
   input wire logic [6:0] dm_addr,
   input wire logic dm_wr,
   input wire logic dm_rd,
   input wire dbt_pkg::dbt_nib_t dm_wdata,
   output dbt_pkg::dbt_nib_t dm_rdata,
   output logic dm_rd_hit,
   input wire logic [5:0] ctl_addr,
   input wire logic ctl_wr,
   input wire logic ctl_rd,
   input wire dbt_pkg::dbt_nib_t ctl_wdata,
   output dbt_pkg::dbt_nib_t ctl_rdata,
   output logic ctl_rd_hit,
   input wire logic tbl_req,
   input wire logic get_req,
   input wire logic put_req,
   input wire logic [6:0] per_sel,
   output logic busy,
   output dbt_pkg::dbt_word_t pm_addr,
   output logic pm_rd,
   input wire dbt_pkg::dbt_word_t pm_rdata,
   output logic stk_push,
   output logic stk_pop,
   output logic [6:0] per_addr,
   output logic per_rd,
   output logic per_wr,
   output dbt_pkg::dbt_word_t per_wdata,
   input wire dbt_pkg::dbt_word_t per_rdata,
   output dbt_pkg::dbt_word_t data_buffer,
   output dbt_pkg::dbt_word_t table_pointer
);
   import dbt_pkg::*;

   // True for bank 0, columns 0C..0F
   function automatic logic buf_hit(input logic [3:0] bank,
                                    input logic [6:0] addr);
      buf_hit = (bank == `DBT_BUF_BANK) &&
                (addr >= `DBT_BUF_TOP_ADDR) && (addr <= `DBT_BUF_BOT_ADDR);
   endfunction

   function automatic dbt_nib_t nib_of(input dbt_word_t w,
                                       input logic [1:0] idx);
      nib_of = w[4'd15 - {idx, 2'b00} -: 4];
   endfunction

   dbt_state_t state_ff, nxt_state;
   logic busy_ff, nxt_busy;
   dbt_word_t ptr_ff, nxt_ptr;
   dbt_nib_t wsel_ff, nxt_wsel;
   dbt_word_t pm_addr_ff, nxt_pm_addr;
   logic pm_rd_ff, nxt_pm_rd;
   logic push_ff, nxt_push;
   logic pop_ff, nxt_pop;
   logic [6:0] per_addr_ff, nxt_per_addr;
   logic per_rd_ff, nxt_per_rd;
   logic per_wr_ff, nxt_per_wr;
   dbt_word_t per_wdata_ff, nxt_per_wdata;
   logic dm_hit_ff, nxt_dm_hit;
   dbt_nib_t ctl_rdata_ff, nxt_ctl_rdata;
   logic ctl_hit_ff, nxt_ctl_hit;
   logic wide_sel;
   logic acc_tbl, acc_get, acc_put;
   logic wide_we;
   logic [3:0] wide_mask;
   dbt_word_t wide_wdata;
   dbt_word_t buf_word;
   logic [1:0] dm_idx;

   assign wide_sel = wsel_ff[`DBT_WSEL_WIDE_BIT];
   assign dm_idx = 2'(dm_addr - `DBT_BUF_TOP_ADDR);
   // One request per idle cycle; table read outranks get, get outranks put
   assign acc_tbl = (state_ff == DBT_IDLE) && tbl_req;
   assign acc_get = (state_ff == DBT_IDLE) && !tbl_req && get_req;
   assign acc_put = (state_ff == DBT_IDLE) && !tbl_req && !get_req && put_req;

   // Single buffer write path shared by table reads and gets
   always_comb begin
      wide_we = 1'b0;
      wide_mask = `DBT_MASK_ALL;
      wide_wdata = pm_rdata;
      unique case (state_ff)
         DBT_IDLE: begin
            if (acc_get && per_sel == `DBT_PER_PTR_ADDR) begin
               wide_we = 1'b1;
               wide_wdata = ptr_ff;
            end
         end
         DBT_TBL_FETCH: begin
            wide_we = 1'b1;
            wide_mask = wide_sel ? `DBT_MASK_ALL : `DBT_MASK_LOW;
            wide_wdata = pm_rdata;
         end
         DBT_GET_WAIT: begin
            wide_we = 1'b1;
            wide_wdata = per_rdata;
         end
         default: begin
            wide_we = 1'b0;
         end
      endcase
   end

   dbt_buf_mem u_mem (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .nib_idx(dm_idx),
      .nib_we(dm_wr && buf_hit(dm_bank, dm_addr)),
      .nib_wdata(dm_wdata),
      .nib_rd(dm_rd && buf_hit(dm_bank, dm_addr)),
      .nib_rdata(dm_rdata),
      .wide_we(wide_we),
      .wide_mask(wide_mask),
      .wide_wdata(wide_wdata),
      .word(buf_word)
   );

   always_comb begin
      nxt_state = state_ff;
      nxt_ptr = ptr_ff;
      nxt_pm_addr = pm_addr_ff;
      nxt_pm_rd = 1'b0;
      nxt_push = 1'b0;
      nxt_pop = 1'b0;
      nxt_per_addr = per_addr_ff;
      nxt_per_rd = 1'b0;
      nxt_per_wr = 1'b0;
      nxt_per_wdata = per_wdata_ff;
      unique case (state_ff)
         DBT_IDLE: begin
            if (acc_tbl) begin
               nxt_pm_addr = ptr_ff;
               nxt_pm_rd = 1'b1;
               nxt_push = 1'b1;
               nxt_state = DBT_TBL_FETCH;
            end else if (acc_get && per_sel != `DBT_PER_PTR_ADDR) begin
               nxt_per_addr = per_sel;
               nxt_per_rd = 1'b1;
               nxt_state = DBT_GET_WAIT;
            end else if (acc_put) begin
               if (per_sel == `DBT_PER_PTR_ADDR) begin
                  nxt_ptr = buf_word;
               end else begin
                  nxt_per_addr = per_sel;
                  nxt_per_wdata = buf_word;
                  nxt_per_wr = 1'b1;
               end
            end
         end
         DBT_TBL_FETCH: begin
            nxt_pop = 1'b1;
            nxt_state = DBT_IDLE;
         end
         DBT_GET_WAIT: begin
            nxt_state = DBT_IDLE;
         end
         default: begin
            nxt_state = DBT_IDLE;
         end
      endcase
      nxt_busy = (nxt_state != DBT_IDLE);
   end

   always_comb begin
      nxt_wsel = wsel_ff;
      nxt_ctl_rdata = ctl_rdata_ff;
      nxt_ctl_hit = ctl_rd && ctl_addr == `DBT_CTL_WIDTH_ADDR;
      nxt_dm_hit = dm_rd && buf_hit(dm_bank, dm_addr);
      if (ctl_wr && ctl_addr == `DBT_CTL_WIDTH_ADDR) begin
         nxt_wsel = ctl_wdata;
      end
      if (nxt_ctl_hit) begin
         nxt_ctl_rdata = wsel_ff;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_ff <= DBT_IDLE;
         busy_ff <= 1'b0;
         ptr_ff <= `DBT_PTR_RST;
         wsel_ff <= `DBT_WSEL_RST;
         pm_addr_ff <= 16'h0000;
         pm_rd_ff <= 1'b0;
         push_ff <= 1'b0;
         pop_ff <= 1'b0;
         per_addr_ff <= 7'h00;
         per_rd_ff <= 1'b0;
         per_wr_ff <= 1'b0;
         per_wdata_ff <= 16'h0000;
         dm_hit_ff <= 1'b0;
         ctl_rdata_ff <= 4'h0;
         ctl_hit_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         busy_ff <= nxt_busy;
         ptr_ff <= nxt_ptr;
         wsel_ff <= nxt_wsel;
         pm_addr_ff <= nxt_pm_addr;
         pm_rd_ff <= nxt_pm_rd;
         push_ff <= nxt_push;
         pop_ff <= nxt_pop;
         per_addr_ff <= nxt_per_addr;
         per_rd_ff <= nxt_per_rd;
         per_wr_ff <= nxt_per_wr;
         per_wdata_ff <= nxt_per_wdata;
         dm_hit_ff <= nxt_dm_hit;
         ctl_rdata_ff <= nxt_ctl_rdata;
         ctl_hit_ff <= nxt_ctl_hit;
      end
   end

   // Busy covers only the wait states; a put finishes in its accept cycle
   assign busy = busy_ff;
   assign pm_addr = pm_addr_ff;
   assign pm_rd = pm_rd_ff;
   assign stk_push = push_ff;
   assign stk_pop = pop_ff;
   assign per_addr = per_addr_ff;
   assign per_rd = per_rd_ff;
   assign per_wr = per_wr_ff;
   assign per_wdata = per_wdata_ff;
   assign dm_rd_hit = dm_hit_ff;
   assign ctl_rdata = ctl_rdata_ff;
   assign ctl_rd_hit = ctl_hit_ff;
   assign data_buffer = buf_word;
   assign table_pointer = ptr_ff;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   AST_TBL_FETCH: assert property (
      acc_tbl |=> pm_rd && pm_addr == $past(ptr_ff) && stk_push)
      else $error("table read did not fetch at the pointer");

   AST_TBL_FULL_ADDR: assert property (
      acc_tbl && ptr_ff == 16'hffff |=> pm_rd && pm_addr == 16'hffff)
      else $error("top program address not reachable");

   AST_TBL_WIDE: assert property (
      pm_rd && wide_sel |=> data_buffer == $past(pm_rdata))
      else $error("16-bit table read did not fill the buffer");

   AST_TBL_NARROW: assert property (
      pm_rd && !wide_sel |=> data_buffer[7:0] == $past(pm_rdata[7:0])
         && data_buffer[15:8] == $past(data_buffer[15:8]))
      else $error("8-bit table read touched the high nibbles");

   AST_STACK_LEVEL: assert property (
      stk_push |=> stk_pop && !stk_push ##1 !stk_pop)
      else $error("stack level not released after one cycle");

   AST_WSEL: assert property (
      ctl_wr && ctl_addr == `DBT_CTL_WIDTH_ADDR
      |=> wide_sel == $past(ctl_wdata[`DBT_WSEL_WIDE_BIT]))
      else $error("width selection not taken");

   AST_GET_EXT: assert property (
      acc_get && per_sel != `DBT_PER_PTR_ADDR
      |=> per_rd && per_addr == $past(per_sel)
      ##1 data_buffer == $past(per_rdata))
      else $error("peripheral read did not load the buffer");

   AST_PUT_EXT: assert property (
      acc_put && per_sel != `DBT_PER_PTR_ADDR
      |=> per_wr && per_wdata == $past(data_buffer)
         && per_addr == $past(per_sel))
      else $error("peripheral write did not carry the buffer");

   AST_PTR_PORT: assert property (
      acc_put && per_sel == `DBT_PER_PTR_ADDR
      |=> table_pointer == $past(data_buffer) && !per_wr)
      else $error("table pointer not written through the buffer");

   AST_PTR_HOLD: assert property (
      !(acc_put && per_sel == `DBT_PER_PTR_ADDR)
      |=> table_pointer == $past(table_pointer))
      else $error("table pointer changed without a put");

   AST_PTR_GET: assert property (
      acc_get && per_sel == `DBT_PER_PTR_ADDR
      |=> data_buffer == $past(table_pointer) && !per_rd && !busy)
      else $error("table pointer not read into the buffer");

   AST_DM_NIB: assert property (
      dm_wr && buf_hit(dm_bank, dm_addr) && !wide_we
      |=> nib_of(data_buffer, $past(dm_idx)) == $past(dm_wdata))
      else $error("core write missed its buffer nibble");

   AST_DM_TOP: assert property (
      dm_wr && dm_bank == `DBT_BUF_BANK && dm_addr == `DBT_BUF_TOP_ADDR
      && !wide_we |=> data_buffer[15:12] == $past(dm_wdata))
      else $error("top nibble not at the buffer MSB");

   AST_DM_READ: assert property (
      dm_rd && buf_hit(dm_bank, dm_addr)
      |=> dm_rd_hit && dm_rdata == nib_of($past(data_buffer), $past(dm_idx)))
      else $error("core read of buffer nibble wrong");

   COV_TBL_WIDE: cover property (acc_tbl && wide_sel ##1 pm_rd ##1 stk_pop);
   COV_TBL_NARROW: cover property (acc_tbl && !wide_sel ##2 stk_pop);
   COV_GET_EXT: cover property (acc_get ##1 per_rd ##1 !busy);
   COV_PUT_PTR: cover property (acc_put && per_sel == `DBT_PER_PTR_ADDR);
endmodule // dbt_top

/* verif/dbt_far_model.sv */
module dbt_far_model (
   input wire logic ref_clk,
   input wire dbt_pkg::dbt_word_t pm_addr,
   input wire logic pm_rd,
   output dbt_pkg::dbt_word_t pm_rdata,
   input wire logic [6:0] per_addr,
   input wire logic per_rd,
   input wire logic per_wr,
   input wire dbt_pkg::dbt_word_t per_wdata,
   output dbt_pkg::dbt_word_t per_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import dbt_pkg::*;
   dbt_word_t regs [128];
   dbt_word_t junk = 16'h0000;
   // Lines not being read change every cycle so stale data cannot pass
   always @(posedge ref_clk) begin
      junk <= junk + 16'h9e37;
      if (per_wr) begin
         regs[per_addr] <= per_wdata;
      end
   end
   // Byte-swapped pattern gives every address its own word
   assign pm_rdata = pm_rd ? ({pm_addr[7:0], pm_addr[15:8]} ^ 16'h3c5a)
                           : junk;
   assign per_rdata = per_rd ? regs[per_addr] : ~junk;
endmodule // dbt_far_model

/* verif/dbt_tb_top.sv */
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
   error_cnt++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); \
   end end

module dbt_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dbt_pkg::*;
   typedef struct packed {
      dbt_word_t ptr;
      dbt_nib_t wsel;
      dbt_word_t pre;
      dbt_word_t exp;
   } dbt_row_t;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] dm_bank = 4'h0;
   logic [6:0] dm_addr = 7'h00;
   logic dm_wr = 1'b0;
   logic dm_rd = 1'b0;
   dbt_nib_t dm_wdata = 4'h0;
   dbt_nib_t dm_rdata;
   logic dm_rd_hit;
   logic [5:0] ctl_addr = 6'h07;
   logic ctl_wr = 1'b0;
   logic ctl_rd = 1'b0;
   dbt_nib_t ctl_wdata = 4'h0;
   dbt_nib_t ctl_rdata;
   logic ctl_rd_hit;
   logic tbl_req = 1'b0;
   logic get_req = 1'b0;
   logic put_req = 1'b0;
   logic [6:0] per_sel = 7'h00;
   logic busy, pm_rd, stk_push, stk_pop, per_rd, per_wr;
   logic [6:0] per_addr;
   dbt_word_t pm_addr, pm_rdata, per_wdata, per_rdata;
   dbt_word_t data_buffer, table_pointer;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   // Expected words follow the far model's byte-swapped pattern
   dbt_row_t rows [4] = '{
      '{16'h0000, 4'h0, 16'h1111, 16'h115a},
      '{16'hffff, 4'h1, 16'h2222, 16'hc3a5},
      '{16'h1234, 4'h1, 16'h0000, 16'h0848},
      '{16'h8001, 4'he, 16'habcd, 16'habda}};

   always #5 ref_clk = ~ref_clk;

   dbt_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .dm_bank(dm_bank),
      .dm_addr(dm_addr), .dm_wr(dm_wr), .dm_rd(dm_rd), .dm_wdata(dm_wdata),
      .dm_rdata(dm_rdata), .dm_rd_hit(dm_rd_hit), .ctl_addr(ctl_addr),
      .ctl_wr(ctl_wr), .ctl_rd(ctl_rd), .ctl_wdata(ctl_wdata),
      .ctl_rdata(ctl_rdata), .ctl_rd_hit(ctl_rd_hit), .tbl_req(tbl_req),
      .get_req(get_req), .put_req(put_req), .per_sel(per_sel),
      .busy(busy), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
      .stk_push(stk_push), .stk_pop(stk_pop), .per_addr(per_addr),
      .per_rd(per_rd), .per_wr(per_wr), .per_wdata(per_wdata),
      .per_rdata(per_rdata), .data_buffer(data_buffer),
      .table_pointer(table_pointer));

   dbt_far_model u_far (.ref_clk(ref_clk), .pm_addr(pm_addr),
      .pm_rd(pm_rd), .pm_rdata(pm_rdata), .per_addr(per_addr),
      .per_rd(per_rd), .per_wr(per_wr), .per_wdata(per_wdata),
      .per_rdata(per_rdata));

   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Back-to-back nibble writes, one per cycle, top nibble first
   task automatic set_buf(input dbt_word_t w);
      dm_wr = 1'b1;
      dm_bank = 4'h0;
      for (int i = 0; i < 4; i++) begin
         dm_addr = 7'h0c + 7'(i);
         dm_wdata = w[15 - 4*i -: 4];
         @(negedge ref_clk);
      end
      dm_wr = 1'b0;
      `CHK(data_buffer, w)
   endtask

   // Returns in the cycle after the request edge
   task automatic issue(input logic t, g, p, input logic [6:0] a);
      tbl_req = t;
      get_req = g;
      put_req = p;
      per_sel = a;
      @(negedge ref_clk);
      tbl_req = 1'b0;
      get_req = 1'b0;
      put_req = 1'b0;
   endtask

   task automatic tbl_chk(input dbt_word_t exp, input dbt_word_t ptr);
      issue(1'b1, 1'b0, 1'b0, 7'h00);
      `CHK({pm_rd, stk_push, busy}, 3'b111)
      `CHK(pm_addr, ptr)
      @(negedge ref_clk);
      `CHK({stk_pop, busy}, 2'b10)
      `CHK(data_buffer, exp)
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         wrap_up();
      end
   end

   initial begin
      repeat (6) @(negedge ref_clk);
      rst_n = 1'b1;
      `CHK({busy, pm_rd, stk_push, data_buffer}, 19'h0)
      foreach (rows[i]) begin
         set_buf(rows[i].ptr);
         issue(1'b0, 1'b0, 1'b1, 7'h40);
         `CHK({per_wr, table_pointer}, {1'b0, rows[i].ptr})
         set_buf(rows[i].pre);
         ctl_wdata = rows[i].wsel;
         ctl_wr = 1'b1;
         @(negedge ref_clk);
         ctl_wr = 1'b0;
         ctl_rd = 1'b1;
         @(negedge ref_clk);
         ctl_rd = 1'b0;
         `CHK({ctl_rd_hit, ctl_rdata}, {1'b1, rows[i].wsel})
         tbl_chk(rows[i].exp, rows[i].ptr);
      end
      tbl_chk(16'habda, 16'h8001);
      // Writes outside bank 0 or outside 0C..0F leave the buffer alone
      dm_wr = 1'b1;
      dm_bank = 4'h1;
      dm_addr = 7'h0c;
      dm_wdata = 4'h0;
      @(negedge ref_clk);
      dm_bank = 4'h0;
      dm_addr = 7'h0b;
      @(negedge ref_clk);
      dm_wr = 1'b0;
      `CHK(data_buffer, 16'habda)
      dm_rd = 1'b1;
      @(negedge ref_clk);
      dm_addr = 7'h0d;
      `CHK(dm_rd_hit, 1'b0)
      @(negedge ref_clk);
      dm_rd = 1'b0;
      `CHK({dm_rd_hit, dm_rdata}, {1'b1, 4'hb})
      set_buf(16'hbeef);
      issue(1'b0, 1'b0, 1'b1, 7'h42);
      `CHK({per_wr, per_addr, per_wdata}, {8'hc2, 16'hbeef})
      set_buf(16'h0000);
      issue(1'b0, 1'b1, 1'b0, 7'h42);
      `CHK({per_rd, busy, per_addr}, {2'b11, 7'h42})
      @(negedge ref_clk);
      `CHK(data_buffer, 16'hbeef)
      get_req = 1'b1;
      per_sel = 7'h40;
      @(negedge ref_clk);
      // Table read wins over get; a put while busy is dropped
      tbl_req = 1'b1;
      per_sel = 7'h42;
      `CHK({busy, per_rd, data_buffer}, {2'b00, 16'h8001})
      @(negedge ref_clk);
      tbl_req = 1'b0;
      get_req = 1'b0;
      put_req = 1'b1;
      `CHK({pm_rd, per_rd}, 2'b10)
      @(negedge ref_clk);
      put_req = 1'b0;
      `CHK({per_wr, data_buffer}, {1'b0, 16'h80da})
      rst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      rst_n = 1'b1;
      `CHK({busy, data_buffer, table_pointer}, 33'h0)
      tbl_chk(16'h005a, 16'h0000);
      wrap_up();
   end
endmodule // dbt_tb_top
